//--- bench/lacs_host.sv
// Host model: classic Wishbone master that programs and reads the scaler.
// Assumes the bench pops exp_q in order whenever read data is acknowledged.
`timescale 1ns/1ps
module lacs_host (
  input wire logic clk_i,
  input wire logic ack_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [3:0] sel_o,
  output logic [7:0] adr_o,
  output logic [31:0] dat_o
);
  logic [31:0] exp_q[$];
  initial {cyc_o, stb_o, we_o, sel_o, adr_o, dat_o} = '0;

  // Held until ack is sampled, then one idle cycle before the next request
  // No own limit: only the bench watchdog ends a wait that never gets an ack
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, sel_o, adr_o, dat_o} <= {2'b11, w, 4'hf, a, d};
    @(posedge clk_i);
    while (ack_i !== 1'b1)
    begin
      @(posedge clk_i);
    end
    {cyc_o, stb_o, we_o, sel_o} <= 7'h00;
  endtask : xfer

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask : rd
endmodule : lacs_host

//--- bench/testbench.sv
// Self-checking bench: host model on the register bus, bench drives steps.
// Assumes the host model owns the register bus; the model below tracks load and scale.
`timescale 1ns/1ps
module testbench;
  import lacs_pkg::*;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, full_step_i, stall_output_o, irq_o;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o;
  logic [9:0] load_meas_i;
  logic [6:0] sensitivity_threshold_o;
  lacs_coil_t [1:0] coil_i, coil_o;
  int errors = 0, total_checks = 0;
  int sc = 31, cs = 31, lt, uw, inc, dec, mc, flt, cnt, fn, fs, ld = 1023;
  int dn[4] = '{32, 8, 2, 1};

  lacs_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .full_step_i(full_step_i), .load_meas_i(load_meas_i), .coil_i(coil_i), .coil_o(coil_o),
    .sensitivity_threshold_o(sensitivity_threshold_o), .stall_output_o(stall_output_o), .irq_o(irq_o));
  lacs_host host (.clk_i(clk_i), .ack_i(ack_o), .cyc_o(cyc_i), .stb_o(stb_i), .we_o(we_i),
    .sel_o(sel_i), .adr_o(adr_i), .dat_o(dat_i));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude;
    if (errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude

  function automatic int fl();
    int f;
    f = ((cs + 1) >> (mc ? 2 : 1)) - 1;
    return f < 0 ? 0 : f;
  endfunction : fl

  // Read data is judged in ack order against the host's notes
  always @(posedge clk_i)
    if (ack_o === 1'b1 && we_i === 1'b0)
      check(dat_o, host.exp_q.pop_front());

  task automatic setc(input int c, input int f, input int m, input int d, input int i, input int w, input int l);
    if (f != flt)
      {fn, fs} = '0;
    {cs, flt, mc, dec, inc, uw, lt} = {c, f, m, d, i, w, l};
    host.xfer(1'b1, 8'h00, {1'b0, 7'h45, 3'h0, c[4:0], 2'h0, f[0], m[0], d[1:0], i[1:0], w[3:0], l[3:0]});
    if (sc > cs)
      sc = cs;
    if (sc < fl())
      sc = fl();
    // The write lands at the ack edge; look once it has settled
    @(negedge clk_i);
    check(sensitivity_threshold_o, 7'h45);
  endtask : setc

  task automatic step(input int m);
    int r;
    @(posedge clk_i);
    full_step_i <= 1'b1;
    load_meas_i <= m[9:0];
    @(posedge clk_i);
    full_step_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    fs += m;
    fn++;
    if (!flt || fn == 4)
    begin
      r = flt ? fs >> 2 : m;
      {fn, fs} = '0;
      ld = r;
      if (r < lt * 32)
      begin
        cnt = 0;
        sc = (sc + (1 << inc) > cs) ? cs : sc + (1 << inc);
      end
      else if (r >= (lt + uw + 1) * 32)
      begin
        cnt++;
        if (cnt >= dn[dec])
        begin
          cnt = 0;
          if (sc > fl())
            sc--;
        end
      end
      else
        cnt = 0;
    end
    check(stall_output_o, ld == 0);
    check(coil_o[1], (200 * (sc + 1)) >> 5);
    check(coil_o[0], (coil_i[0] * (sc + 1)) >> 5);
    host.rd(8'h04, {7'h0, ld == 0, 3'h0, sc[4:0], 6'h0, ld[9:0]});
  endtask : step

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Longest path is about 1400 cycles; this limit of 40000 cycles leaves a wide margin
  initial
  begin
    #(25 * 40000);
    errors++;
    conclude();
  end

  initial
  begin
    rst_i = 1'b1;
    full_step_i = 1'b0;
    load_meas_i = 10'h0;
    void'($urandom(89352));
    coil_i = {8'hc8, 8'($urandom)};
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    host.rd(8'h04, 32'h001f03ff);
    host.rd(8'h00, 32'h001f0000);
    host.rd(8'h40, 32'h0);
    host.rd(8'h0c, 32'h0);
    host.xfer(1'b1, 8'h04, 32'hffff_ffff);
    step(0);
    setc(31, 0, 0, 3, 0, 0, 1);
    repeat (18) step(1023);
    setc(31, 0, 1, 3, 0, 0, 1);
    repeat (10) step(64);
    for (int i = 0; i < 4; i++)
    begin
      setc(31, 0, 1, 3, i, 0, 1);
      repeat (2) step(31);
    end
    setc(31, 0, 1, 0, 0, 0, 1);
    repeat (31) step(700);
    step(40);
    repeat (32) step(700);
    setc(20, 0, 0, 0, 0, 0, 1);
    step(500);
    setc(31, 1, 0, 3, 1, 2, 2);
    repeat (8) step($urandom_range(1023));
    setc(31, 0, $urandom_range(1), $urandom_range(3), $urandom_range(3), $urandom_range(15), $urandom_range(15));
    repeat (20) step($urandom_range(1023));
    host.xfer(1'b1, 8'h10, 32'h2);
    host.rd(8'h10, 32'h2);
    step(300);
    check(irq_o, 1'b1);
    host.xfer(1'b1, 8'h0c, 32'hf);
    repeat (2) @(posedge clk_i);
    check(irq_o, 1'b0);
    host.rd(8'h08, 32'h0);
    host.xfer(1'b1, 8'h10, 32'h0);
    step(300);
    check(irq_o, 1'b0);
    conclude();
  end
endmodule : testbench

//--- hdl/lacs_consts.svh
// Constants for the load-adaptive current scaler: offsets, field positions,
// reset values and widths. Included by the package and the design files.
`ifndef LACS_CONSTS_SVH
`define LACS_CONSTS_SVH

`define LACS_LOAD_W 10
`define LACS_SCALE_W 5
`define LACS_COIL_W 8
`define LACS_THR_SHIFT 5
`define LACS_FILT_DEPTH 4
`define LACS_FILT_SHIFT 2

// Register byte offsets
`define LACS_OFF_CTRL 8'h00
`define LACS_OFF_STATUS 8'h04
`define LACS_OFF_IRQ_STAT 8'h08
`define LACS_OFF_IRQ_CLR 8'h0c
`define LACS_OFF_IRQ_EN 8'h10

// Control register fields (low bit positions)
`define LACS_F_LOWER_THR 0
`define LACS_F_UPPER_WIN 4
`define LACS_F_INC_SEL 8
`define LACS_F_DEC_SEL 10
`define LACS_F_MIN_CUR 12
`define LACS_F_FILT_EN 13
`define LACS_F_CUR_SCALE 16
`define LACS_F_SENS_THR 24

// Status register fields
`define LACS_F_ST_LOAD 0
`define LACS_F_ST_SCALE 16
`define LACS_F_ST_STALL 24

// Reset values and the interrupt width
`define LACS_CTRL_RST 32'h001f_0000
`define LACS_LOAD_RST 10'h3ff
`define LACS_SCALE_RST 5'h1f
`define LACS_IRQ_W 4

`endif

//--- hdl/lacs_load_filter.sv
// Per-full-step load sampler with optional four-sample averaging.
// Assumes step_i is a one-cycle pulse per full step with meas_i valid then.
`timescale 1ns/1ps
`include "lacs_consts.svh"

module lacs_load_filter #(
  parameter int LOAD_W = `LACS_LOAD_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic step_i,
  input wire logic [LOAD_W-1:0] meas_i,
  input wire logic filt_en_i,
  output logic [LOAD_W-1:0] res_o,
  output logic res_valid_o
);
  import lacs_pkg::*;

  localparam int SUM_W = LOAD_W + `LACS_FILT_SHIFT;

  logic [SUM_W-1:0] sum_q, sum_d, sum_n;
  logic [1:0] cnt_q, cnt_d;
  logic [LOAD_W-1:0] res_q, res_d;
  logic valid_q, valid_d;

  if (LOAD_W < 1 || LOAD_W > 16) begin : g_chk
    $error("lacs_load_filter: LOAD_W out of range");
  end

  always_comb
  begin
    sum_n = sum_q + SUM_W'(meas_i);
    sum_d = sum_q;
    cnt_d = cnt_q;
    res_d = res_q;
    valid_d = 1'b0;
    if (!filt_en_i)
    begin
      // Restart the average so a later enable sees four fresh samples
      sum_d = '0;
      cnt_d = 2'd0;
      if (step_i)
      begin
        res_d = meas_i; // RULE2
        valid_d = 1'b1; // RULE1
      end
    end
    else if (step_i)
    begin
      if (cnt_q == 2'd3)
      begin
        res_d = sum_n[SUM_W-1:`LACS_FILT_SHIFT]; // RULE2
        valid_d = 1'b1; // RULE13
        sum_d = '0;
        cnt_d = 2'd0;
      end
      else
      begin
        sum_d = sum_n;
        cnt_d = cnt_q + 2'd1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sum_q <= '0;
      cnt_q <= 2'd0;
      res_q <= LOAD_W'(`LACS_LOAD_RST);
      valid_q <= 1'b0;
    end
    else
    begin
      sum_q <= sum_d;
      cnt_q <= cnt_d;
      res_q <= res_d;
      valid_q <= valid_d;
    end
  end

  assign res_o = res_q;
  assign res_valid_o = valid_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_raw_pass: assert property ((step_i && !filt_en_i) |=> (res_valid_o && res_o == $past(meas_i))) // RULE2
    else $error("raw sample not passed through");
  chk_filter_rate: assert property ((filt_en_i && step_i && cnt_q != 2'd3) |=> !res_valid_o) // RULE13
    else $error("filtered result issued early");

endmodule : lacs_load_filter

//--- hdl/lacs_pkg.sv
// Types shared by the load-adaptive current scaler files.
// Assumes lacs_consts.svh is on the include path.
`include "lacs_consts.svh"

package lacs_pkg;

  typedef logic [`LACS_COIL_W-1:0] lacs_coil_t;

  typedef struct packed {
    logic [6:0] sens_thr;
    logic [4:0] cur_scale;
    logic filt_en;
    logic min_cur_sel;
    logic [1:0] dec_sel;
    logic [1:0] inc_sel;
    logic [3:0] upper_win;
    logic [3:0] lower_thr;
  } lacs_cfg_t;

  typedef struct packed {
    logic scale_dn;
    logic scale_up;
    logic new_load;
    logic stall;
  } lacs_irq_t;

endpackage : lacs_pkg

//--- hdl/lacs_top.sv
// Load-adaptive current scaler: load sampling, stall flag, adaptive scale,
// coil scaling, classic Wishbone register slave and an interrupt.
// Assumes full_step_i pulses once per full step with load_meas_i valid then.
//
// Overview of operation
// RULE1: Load value refreshes once per full step and holds between steps.
// RULE2: Filter bit set averages four measurements; clear passes raw value.
// RULE3: Stall output high while the load value is zero.
// RULE4: Lower threshold is lower parameter times 32; below it current rises.
// RULE5: Upper threshold is (lower + window + 1) times 32; at/above counts down.
// RULE6: Each below-lower result raises scale by 1, 2, 4 or 8.
// RULE7: Scale drops by one after 32, 8, 2 or 1 at/above-upper results.
// RULE8: Scale floor is quarter of current scale if minimum bit set, else half.
// RULE9: Both coil values scaled by 5-bit scale, meaning 1/32 to 32/32.
// RULE10: Adaptive scale in use is readable as a 5-bit status, biased by one.
// RULE11: Adaptive scale saturates between floor and programmed current scale.
// RULE12: Load value is 10-bit unsigned; zero means highest load.
// RULE13: With filter on, one result per four full steps.
// RULE14: Host programs a 7-bit signed sensitivity threshold.
// RULE15: Upper-count clears after each decrement and on any lower result.
// RULE16: Comparisons and scale change happen the cycle after a new result.
`timescale 1ns/1ps
`include "lacs_consts.svh"

module lacs_top #(
  parameter int COIL_W = `LACS_COIL_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic full_step_i,
  input wire logic [`LACS_LOAD_W-1:0] load_meas_i,
  input wire lacs_pkg::lacs_coil_t [1:0] coil_i,
  output lacs_pkg::lacs_coil_t [1:0] coil_o,
  output logic [6:0] sensitivity_threshold_o,
  output logic stall_output_o,
  output logic irq_o
);
  import lacs_pkg::*;

  localparam int LW = `LACS_LOAD_W;
  localparam int SW = `LACS_SCALE_W;

  if (COIL_W != $bits(lacs_coil_t)) begin : g_chk
    $error("lacs_top: COIL_W must match lacs_coil_t");
  end

  function automatic logic [SW:0] inc_step(input logic [1:0] sel);
    inc_step = (SW+1)'(1) << sel;
  endfunction : inc_step

  function automatic logic [5:0] dec_count(input logic [1:0] sel);
    case (sel)
      2'd0: dec_count = 6'd32;
      2'd1: dec_count = 6'd8;
      2'd2: dec_count = 6'd2;
      default: dec_count = 6'd1;
    endcase
  endfunction : dec_count

  // Bus slave state
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic [31:0] ctrl_q, ctrl_d;
  logic [`LACS_IRQ_W-1:0] ist_q, ist_d, ien_q, ien_d;
  logic irq_q, irq_d;
  logic req, wr_go, ctrl_wr;

  // Datapath state
  logic [LW-1:0] load_q, load_d;
  logic eval_q, eval_d;
  logic stall_q, stall_d;
  logic [SW-1:0] ascale_q, ascale_d;
  logic [5:0] dcnt_q, dcnt_d;
  lacs_coil_t [1:0] coil_q, coil_d;

  logic [LW-1:0] f_res;
  logic f_valid;
  lacs_cfg_t cfg;
  lacs_irq_t ev;
  logic [LW:0] lower_thr, upper_thr;
  logic below, at_upper;
  logic [SW:0] cs_real, min_real;
  logic [SW-1:0] min_scale;
  logic [SW+1:0] ascale_work;

  lacs_load_filter #(
    .LOAD_W(LW)
  ) u_filter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .step_i(full_step_i),
    .meas_i(load_meas_i),
    .filt_en_i(cfg.filt_en),
    .res_o(f_res),
    .res_valid_o(f_valid)
  );

  always_comb
  begin
    cfg.lower_thr = ctrl_q[`LACS_F_LOWER_THR +: 4];
    cfg.upper_win = ctrl_q[`LACS_F_UPPER_WIN +: 4];
    cfg.inc_sel = ctrl_q[`LACS_F_INC_SEL +: 2];
    cfg.dec_sel = ctrl_q[`LACS_F_DEC_SEL +: 2];
    cfg.min_cur_sel = ctrl_q[`LACS_F_MIN_CUR];
    cfg.filt_en = ctrl_q[`LACS_F_FILT_EN];
    cfg.cur_scale = ctrl_q[`LACS_F_CUR_SCALE +: SW];
    cfg.sens_thr = ctrl_q[`LACS_F_SENS_THR +: 7]; // RULE14
  end

  // Thresholds and floor
  always_comb
  begin
    lower_thr = (LW+1)'(cfg.lower_thr) << `LACS_THR_SHIFT; // RULE4
    upper_thr = ((LW+1)'(cfg.lower_thr) + (LW+1)'(cfg.upper_win) + (LW+1)'(1)) << `LACS_THR_SHIFT; // RULE5
    below = {1'b0, load_q} < lower_thr; // RULE4
    at_upper = {1'b0, load_q} >= upper_thr; // RULE5
    cs_real = (SW+1)'(cfg.cur_scale) + (SW+1)'(1);
    // Floor on the true fraction, then back to the biased code
    min_real = cfg.min_cur_sel ? (cs_real >> 2) : (cs_real >> 1); // RULE8
    min_scale = (min_real == '0) ? '0 : SW'(min_real - (SW+1)'(1));
  end

  // Load, stall and adaptive scale
  always_comb
  begin
    load_d = load_q;
    eval_d = f_valid; // RULE16
    if (f_valid)
    begin
      load_d = f_res; // RULE1 RULE12
    end
    stall_d = (load_d == '0); // RULE3
    dcnt_d = dcnt_q;
    ascale_work = (SW+2)'(ascale_q);
    if (eval_q)
    begin
      if (below)
      begin
        ascale_work = (SW+2)'(ascale_q) + (SW+2)'(inc_step(cfg.inc_sel)); // RULE6
      end
      if (!at_upper)
      begin
        dcnt_d = 6'd0; // RULE15
      end
      else if (dcnt_q + 6'd1 >= dec_count(cfg.dec_sel))
      begin
        dcnt_d = 6'd0; // RULE15
        ascale_work = (ascale_q == '0) ? '0 : (SW+2)'(ascale_q) - (SW+2)'(1); // RULE7
      end
      else
      begin
        dcnt_d = dcnt_q + 6'd1; // RULE7
      end
    end
    // Clamping every cycle also tracks a rewritten current scale
    if (ascale_work > (SW+2)'(cfg.cur_scale))
    begin
      ascale_d = cfg.cur_scale; // RULE11 RULE9
    end
    else if (ascale_work < (SW+2)'(min_scale))
    begin
      ascale_d = min_scale; // RULE8 RULE11
    end
    else
    begin
      ascale_d = ascale_work[SW-1:0];
    end
  end

  // Coil scaling by the scale in use
  for (genvar i = 0; i < 2; i++) begin : g_coil
    logic [COIL_W+SW:0] prod;
    assign prod = coil_i[i] * ((SW+1)'(ascale_q) + (SW+1)'(1)); // RULE9
    assign coil_d[i] = prod[SW +: COIL_W];
  end

  // Bus: ack one cycle after the request, write at the ack edge
  always_comb
  begin
    req = cyc_i && stb_i;
    wr_go = req && we_i && ack_q;
    ctrl_wr = wr_go && (adr_i == `LACS_OFF_CTRL);
    ack_d = req && !ack_q;
    rdat_d = '0;
    case (adr_i)
      `LACS_OFF_CTRL: rdat_d = ctrl_q;
      `LACS_OFF_STATUS:
      begin
        rdat_d[`LACS_F_ST_LOAD +: LW] = load_q;
        rdat_d[`LACS_F_ST_SCALE +: SW] = ascale_q; // RULE10
        rdat_d[`LACS_F_ST_STALL] = stall_q;
      end
      `LACS_OFF_IRQ_STAT: rdat_d[`LACS_IRQ_W-1:0] = ist_q;
      `LACS_OFF_IRQ_EN: rdat_d[`LACS_IRQ_W-1:0] = ien_q;
      default: rdat_d = '0;
    endcase
    if (!req || ack_q || we_i)
    begin
      rdat_d = '0;
    end
    ctrl_d = ctrl_q;
    ien_d = ien_q;
    if (ctrl_wr)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (sel_i[b])
        begin
          ctrl_d[b*8 +: 8] = dat_i[b*8 +: 8];
        end
      end
    end
    if (wr_go && adr_i == `LACS_OFF_IRQ_EN && sel_i[0])
    begin
      ien_d = dat_i[`LACS_IRQ_W-1:0];
    end
    ev.stall = stall_d && !stall_q;
    ev.new_load = eval_q;
    ev.scale_up = ascale_d > ascale_q;
    ev.scale_dn = ascale_d < ascale_q;
    ist_d = ist_q;
    if (wr_go && adr_i == `LACS_OFF_IRQ_CLR && sel_i[0])
    begin
      ist_d = ist_q & ~dat_i[`LACS_IRQ_W-1:0];
    end
    // Set after clear so a same-cycle event is kept
    ist_d = ist_d | ev;
    irq_d = |(ist_q & ien_q);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      rdat_q <= '0;
      ctrl_q <= `LACS_CTRL_RST;
      ist_q <= '0;
      ien_q <= '0;
      irq_q <= 1'b0;
      load_q <= `LACS_LOAD_RST;
      eval_q <= 1'b0;
      stall_q <= 1'b0;
      ascale_q <= `LACS_SCALE_RST;
      dcnt_q <= 6'd0;
      coil_q <= '0;
    end
    else
    begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      ctrl_q <= ctrl_d;
      ist_q <= ist_d;
      ien_q <= ien_d;
      irq_q <= irq_d;
      load_q <= load_d;
      eval_q <= eval_d;
      stall_q <= stall_d;
      ascale_q <= ascale_d;
      dcnt_q <= dcnt_d;
      coil_q <= coil_d;
    end
  end

  assign ack_o = ack_q;
  assign dat_o = rdat_q;
  assign coil_o = coil_q;
  assign sensitivity_threshold_o = ctrl_q[`LACS_F_SENS_THR +: 7];
  assign stall_output_o = stall_q;
  assign irq_o = irq_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_load_hold: assert property (!f_valid |=> $stable(load_q)) // RULE1
    else $error("load value changed without a new result");
  chk_stall_zero: assert property ((load_d == '0) |=> stall_output_o) // RULE3
    else $error("stall output low while load value is zero");
  chk_stall_clear: assert property ((load_d != '0) |=> !stall_output_o) // RULE3
    else $error("stall output high while load value is nonzero");
  chk_scale_cap: assert property (##1 ascale_q <= $past(cfg.cur_scale)) // RULE11
    else $error("adaptive scale above current scale");
  chk_scale_floor: assert property (##1 ascale_q >= $past(min_scale)) // RULE8
    else $error("adaptive scale below floor");
  chk_inc_step: assert property ((eval_q && below && !ctrl_wr
      && ascale_q + (SW+2)'(inc_step(cfg.inc_sel)) <= (SW+2)'(cfg.cur_scale))
      |=> ascale_q == $past(ascale_q) + SW'(inc_step(cfg.inc_sel))) // RULE6
    else $error("increment step wrong");
  chk_dec_clear: assert property ((eval_q && !at_upper) |=> dcnt_q == 6'd0) // RULE15
    else $error("upper count not cleared");
  chk_dec_one: assert property ((eval_q && at_upper && cfg.dec_sel == 2'd3 && !ctrl_wr
      && ascale_q > min_scale && ascale_q <= cfg.cur_scale) |=> ascale_q == $past(ascale_q) - SW'(1)) // RULE7
    else $error("decrement not applied");
  chk_idle_stable: assert property ((!eval_q && !ctrl_wr && ascale_q <= cfg.cur_scale && ascale_q >= min_scale)
      |=> $stable(ascale_q)) // RULE16
    else $error("scale changed without a new result");
  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held for two cycles");

endmodule : lacs_top
